// [prs_pkg.sv]
// Constants and types of the processor register set
package prs_pkg;
	localparam int PRS_WORD_W = 36;
	localparam int PRS_ADDR_W = 18;
	localparam int PRS_HALF_W = 18;
	localparam int PRS_EXP_W = 8;
	localparam int PRS_TMR_W = 24;
	localparam int PRS_IND_W = 18;
	localparam int PRS_NUM_X = 8;
	localparam int PRS_NUM_CHAN = 4;
	localparam int PRS_NUM_SLOT = 8;
	localparam int PRS_BLK_W = 3;
	localparam int PRS_OFS_W = 15;
	localparam int PRS_RA_W = 5;
	localparam int PRS_CHAR_N = 6;
	// Register word indices
	localparam logic [4:0] PRS_REG_ACC_UP = 5'h00;
	localparam logic [4:0] PRS_REG_ACC_LO = 5'h01;
	localparam logic [4:0] PRS_REG_X0 = 5'h02;
	localparam logic [4:0] PRS_REG_X7 = 5'h09;
	localparam logic [4:0] PRS_REG_EXP = 5'h0A;
	localparam logic [4:0] PRS_REG_BASE = 5'h0B;
	localparam logic [4:0] PRS_REG_IND = 5'h0C;
	localparam logic [4:0] PRS_REG_TMR = 5'h0D;
	localparam logic [4:0] PRS_REG_NIP = 5'h0E;
	localparam logic [4:0] PRS_REG_STAT = 5'h0F;
	// Timer step
	localparam int PRS_CLK_NS = 40;
	localparam int PRS_TICK_NS = 16000;
	localparam int PRS_TICK_CYC = PRS_TICK_NS / PRS_CLK_NS;
	localparam logic [8:0] PRS_TICK_LAST = 9'(PRS_TICK_CYC - 1);
	// Modifier and designator codes
	localparam logic [1:0] PRS_TM_REG = 2'h0;
	localparam logic [3:0] PRS_TD_NONE = 4'h0;
	localparam logic [3:0] PRS_TD_AU = 4'h1;
	localparam logic [3:0] PRS_TD_QU = 4'h2;
	localparam logic [3:0] PRS_TD_DU = 4'h3;
	localparam logic [3:0] PRS_TD_NIP = 4'h4;
	localparam logic [3:0] PRS_TD_AL = 4'h5;
	localparam logic [3:0] PRS_TD_QL = 4'h6;
	localparam logic [3:0] PRS_TD_DL = 4'h7;
	typedef enum logic [1:0] {
		PRS_USE_OPERAND, PRS_USE_SHIFT, PRS_USE_TRANSFER, PRS_USE_SUBOP
	} prs_use_type;
	// Instruction word, bit 35 is the leftmost bit
	typedef struct packed {
		logic [17:0] addr_field;
		logic [9:0] opcode_field;
		logic inhibit;
		logic reserved;
		logic [1:0] modifier_subfield;
		logic [3:0] designator_subfield;
	} prs_instr_type;
	typedef struct packed {
		logic [1:0] channel;
		logic [17:0] phys_addr;
		logic write;
		logic [5:0] char_mask;
		logic [71:0] data;
		logic [1:0] parity;
	} prs_mem_type;
endpackage

// [prs_register_set.sv]
// Program-visible register set with address forming and memory mapping
//
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps
module prs_register_set
	import prs_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [4:0] reg_addr,
	input wire logic [35:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [35:0] reg_rdata,
	input wire logic instr_valid,
	input wire prs_instr_type instr_word,
	input wire prs_use_type instr_use,
	output logic [17:0] eff_addr,
	output logic [5:0] shift_count,
	output logic [9:0] opcode_field,
	output logic [1:0] mod_kind,
	input wire logic privileged,
	input wire logic fault_taken,
	input wire logic ext_interrupt,
	output logic timer_fault_req,
	output logic interrupt_accept,
	input wire logic [17:0] indicator_set,
	input wire logic [23:0] slot_map,
	input wire logic [3:0] installed_blocks,
	input wire logic [17:0] low_mem_base,
	input wire logic mem_req,
	input wire logic mem_fixed,
	input wire logic mem_write,
	input wire logic [5:0] char_mask,
	output prs_mem_type mem_out,
	output logic mem_valid,
	output logic mem_range_err
);
	logic [35:0] acc_upper;
	logic [35:0] acc_lower;
	logic [17:0] index_registers [PRS_NUM_X];
	logic [7:0] exponent_reg;
	logic [17:0] base_address_reg;
	logic [17:0] indicator_reg;
	logic [23:0] interval_timer_reg;
	logic [17:0] next_instruction_pointer;
	logic [8:0] tick_cnt;
	logic tick;
	logic runout_pending;
	logic tmr_load;
	logic inhibit_now;
	logic [71:0] accumulator_pair;
	logic [17:0] upper_acc_high_half;
	logic [17:0] upper_acc_low_half;
	logic [17:0] lower_acc_high_half;
	logic [17:0] lower_acc_low_half;
	logic [17:0] next_eff;
	logic [17:0] index_src;
	logic [17:0] next_addr;
	logic [2:0] slot;
	logic [2:0] phys_blk;
	logic wr_x;
	logic [2:0] x_sel;

	assign accumulator_pair = {acc_upper, acc_lower};
	assign upper_acc_high_half = acc_upper[35:18];
	assign upper_acc_low_half = acc_upper[17:0];
	assign lower_acc_high_half = acc_lower[35:18];
	assign lower_acc_low_half = acc_lower[17:0];
	assign wr_x = reg_wr && reg_addr >= PRS_REG_X0 && reg_addr <= PRS_REG_X7;
	assign x_sel = 3'(reg_addr - PRS_REG_X0);

	// Accumulator words written independently, one word per strobe
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			acc_upper <= 36'h0;
			acc_lower <= 36'h0;
		end else if (reg_wr && reg_addr == PRS_REG_ACC_UP) begin
			acc_upper <= reg_wdata;
		end else if (reg_wr && reg_addr == PRS_REG_ACC_LO) begin
			acc_lower <= reg_wdata;
		end
	end

	generate
		for (genvar n = 0; n < PRS_NUM_X; n++) begin : g_x
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					index_registers[n] <= 18'h0;
				end else if (wr_x && x_sel == 3'(n)) begin
					index_registers[n] <= reg_wdata[17:0];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			exponent_reg <= 8'h0;
			base_address_reg <= 18'h0;
		end else begin
			if (reg_wr && reg_addr == PRS_REG_EXP) begin
				exponent_reg <= reg_wdata[7:0];
			end
			if (reg_wr && reg_addr == PRS_REG_BASE) begin
				base_address_reg <= reg_wdata[17:0];
			end
		end
	end

	// Indicators: whole-register load; hardware sets win over the load
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			indicator_reg <= 18'h0;
		end else if (reg_wr && reg_addr == PRS_REG_IND) begin
			indicator_reg <= reg_wdata[17:0] | indicator_set;
		end else begin
			indicator_reg <= indicator_reg | indicator_set;
		end
	end

	// Prescaler for the timer step
	always_ff @(posedge clk) begin
		if (sys_rst || tick) begin
			tick_cnt <= 9'h0;
		end else begin
			tick_cnt <= tick_cnt + 9'h1;
		end
	end
	assign tick = tick_cnt == PRS_TICK_LAST;
	assign tmr_load = reg_wr && reg_addr == PRS_REG_TMR;

	// A software load takes precedence over the step
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			interval_timer_reg <= 24'h0;
		end else if (reg_wr && reg_addr == PRS_REG_TMR) begin
			interval_timer_reg <= reg_wdata[23:0];
		end else if (tick) begin
			interval_timer_reg <= interval_timer_reg - 24'h1;
		end
	end

	// Runout pending; a new runout beats a take in the same cycle
	// A load in the step cycle replaces the count, so that step never reaches zero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			runout_pending <= 1'b0;
		end else if (tick && interval_timer_reg == 24'h1 && !tmr_load) begin
			runout_pending <= 1'b1;
		end else if (fault_taken && timer_fault_req) begin
			runout_pending <= 1'b0;
		end
	end

	assign inhibit_now = instr_valid && instr_word.inhibit;
	assign timer_fault_req = runout_pending && !privileged && !inhibit_now;
	assign interrupt_accept = (timer_fault_req || ext_interrupt) && !inhibit_now;

	// Index source chosen by the designator
	always_comb begin
		case (instr_word.designator_subfield)
			PRS_TD_NONE: index_src = 18'h0;
			PRS_TD_AU: index_src = upper_acc_high_half;
			PRS_TD_QU: index_src = lower_acc_high_half;
			PRS_TD_AL: index_src = upper_acc_low_half;
			PRS_TD_QL: index_src = lower_acc_low_half;
			PRS_TD_NIP: index_src = next_instruction_pointer;
			PRS_TD_DU: index_src = 18'h0;
			PRS_TD_DL: index_src = 18'h0;
			default: index_src = index_registers[instr_word.designator_subfield[2:0]];
		endcase
	end

	// Register modification adds the index; other kinds pass the field on
	always_comb begin
		if (instr_word.modifier_subfield == PRS_TM_REG) begin
			next_eff = 18'(instr_word.addr_field + index_src);
		end else begin
			next_eff = instr_word.addr_field;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			eff_addr <= 18'h0;
			shift_count <= 6'h0;
			opcode_field <= 10'h0;
			mod_kind <= 2'h0;
		end else if (instr_valid) begin
			eff_addr <= next_eff;
			opcode_field <= instr_word.opcode_field;
			mod_kind <= instr_word.modifier_subfield;
			if (instr_use == PRS_USE_SHIFT) begin
				shift_count <= next_eff[5:0];
			end
		end
	end

	// Transfers load the target, everything else steps by one
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			next_instruction_pointer <= 18'h0;
		end else if (reg_wr && reg_addr == PRS_REG_NIP) begin
			next_instruction_pointer <= reg_wdata[17:0];
		end else if (instr_valid && instr_use == PRS_USE_TRANSFER) begin
			next_instruction_pointer <= next_eff;
		end else if (instr_valid) begin
			next_instruction_pointer <= next_instruction_pointer + 18'h1;
		end
	end

	// Address mapping: fixed locations, slot map and installed range
	assign next_addr = mem_fixed ? 18'(low_mem_base + eff_addr) : eff_addr;
	assign slot = next_addr[17:15];
	assign phys_blk = slot_map[slot * PRS_BLK_W +: PRS_BLK_W];

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mem_out <= '0;
			mem_valid <= 1'b0;
			mem_range_err <= 1'b0;
		end else begin
			mem_valid <= 1'b0;
			mem_range_err <= 1'b0;
			if (mem_req && {1'b0, slot} >= installed_blocks) begin
				mem_range_err <= 1'b1;
			end else if (mem_req) begin
				mem_valid <= 1'b1;
				mem_out.channel <= phys_blk[2:1];
				mem_out.phys_addr <= {phys_blk, next_addr[14:0]};
				mem_out.write <= mem_write;
				mem_out.char_mask <= mem_write ? char_mask : 6'h3F;
				mem_out.data <= accumulator_pair;
				mem_out.parity <= {^acc_upper, ^acc_lower};
			end
		end
	end

	// Read port, data one cycle after the strobe
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= 36'h0;
		end else if (reg_rd) begin
			case (reg_addr)
				PRS_REG_ACC_UP: reg_rdata <= acc_upper;
				PRS_REG_ACC_LO: reg_rdata <= acc_lower;
				PRS_REG_EXP: reg_rdata <= {28'h0, exponent_reg};
				PRS_REG_BASE: reg_rdata <= {18'h0, base_address_reg};
				PRS_REG_IND: reg_rdata <= {18'h0, indicator_reg};
				PRS_REG_TMR: reg_rdata <= {12'h0, interval_timer_reg};
				PRS_REG_NIP: reg_rdata <= {18'h0, next_instruction_pointer};
				// Sign bits of the operand forms and pending runout
				PRS_REG_STAT: reg_rdata <= {30'h0, runout_pending, exponent_reg[7],
					acc_upper[35], acc_upper[17], acc_upper[35], 1'b0};
				default: begin
					if (reg_addr >= PRS_REG_X0 && reg_addr <= PRS_REG_X7) begin
						reg_rdata <= {18'h0, index_registers[x_sel]};
					end else begin
						reg_rdata <= 36'h0;
					end
				end
			endcase
		end else begin
			reg_rdata <= 36'h0;
		end
	end

	sequence s_tmr_load;
		reg_wr && reg_addr == PRS_REG_TMR;
	endsequence
	sequence s_runout;
		tick && interval_timer_reg == 24'h1 && !tmr_load;
	endsequence

	property p_tmr_load;
		@(posedge clk) disable iff (sys_rst)
		s_tmr_load |=> interval_timer_reg == $past(reg_wdata[23:0]);
	endproperty
	a_tmr_load: assert property (p_tmr_load) else $error("timer load lost");

	property p_tick_period;
		@(posedge clk) disable iff (sys_rst) tick |=> !tick [*8];
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("tick too soon");

	property p_tmr_dec;
		@(posedge clk) disable iff (sys_rst)
		tick && !reg_wr |=> interval_timer_reg == $past(interval_timer_reg) - 24'h1;
	endproperty
	a_tmr_dec: assert property (p_tmr_dec) else $error("timer did not step");

	property p_runout_set;
		@(posedge clk) disable iff (sys_rst) s_runout |=> runout_pending;
	endproperty
	a_runout_set: assert property (p_runout_set) else $error("runout lost");

	property p_defer;
		@(posedge clk) disable iff (sys_rst) privileged |-> !timer_fault_req;
	endproperty
	a_defer: assert property (p_defer) else $error("fault in privileged mode");

	property p_sticky;
		@(posedge clk) disable iff (sys_rst)
		runout_pending && !(fault_taken && timer_fault_req) |=> runout_pending;
	endproperty
	a_sticky: assert property (p_sticky) else $error("pending dropped");

	property p_inhibit;
		@(posedge clk) disable iff (sys_rst) inhibit_now |-> !interrupt_accept;
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("interrupt while inhibited");

	property p_nip_step;
		@(posedge clk) disable iff (sys_rst)
		instr_valid && instr_use != PRS_USE_TRANSFER && !reg_wr
		|=> next_instruction_pointer == $past(next_instruction_pointer) + 18'h1;
	endproperty
	a_nip_step: assert property (p_nip_step) else $error("pointer not stepped");

	property p_transfer;
		@(posedge clk) disable iff (sys_rst)
		instr_valid && instr_use == PRS_USE_TRANSFER && !reg_wr
		|=> next_instruction_pointer == eff_addr;
	endproperty
	a_transfer: assert property (p_transfer) else $error("bad transfer target");

	property p_range;
		@(posedge clk) disable iff (sys_rst)
		mem_req |=> mem_valid != mem_range_err;
	endproperty
	a_range: assert property (p_range) else $error("request not answered");

	property p_parity;
		@(posedge clk) disable iff (sys_rst)
		mem_valid |-> mem_out.parity == {^mem_out.data[71:36], ^mem_out.data[35:0]};
	endproperty
	a_parity: assert property (p_parity) else $error("parity mismatch");

	property p_read_lat;
		@(posedge clk) disable iff (sys_rst)
		reg_rd && reg_addr == PRS_REG_EXP |=> reg_rdata == {28'h0, $past(exponent_reg)};
	endproperty
	a_read_lat: assert property (p_read_lat) else $error("read data wrong");

	// A refused access must leave the last mapped access on the channel
	property p_range_hold;
		@(posedge clk) disable iff (sys_rst)
		mem_range_err |-> $stable(mem_out);
	endproperty
	a_range_hold: assert property (p_range_hold) else $error("refused access changed output");

	// Hardware sets reach the register even against a software load
	property p_ind_set;
		@(posedge clk) disable iff (sys_rst)
		|indicator_set |=> (indicator_reg & $past(indicator_set)) == $past(indicator_set);
	endproperty
	a_ind_set: assert property (p_ind_set) else $error("indicator set lost");
endmodule

// [prs_mem_model.sv]
// Memory controller model that accepts mapped requests from the register set
`timescale 1ns/1ps
module prs_mem_model
	import prs_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire prs_mem_type mem_out,
	input wire logic mem_valid,
	output logic [19:0] got_addr,
	output logic got_par_ok,
	output logic [7:0] got_cnt
);
	// Latches channel and address of each accepted access, and checks word parity
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			got_addr <= 20'h00000;
			got_par_ok <= 1'b0;
			got_cnt <= 8'h00;
		end else if (mem_valid) begin
			got_addr <= {mem_out.channel, mem_out.phys_addr};
			got_par_ok <= (mem_out.parity === {^mem_out.data[71:36], ^mem_out.data[35:0]});
			got_cnt <= got_cnt + 8'h01;
		end
	end
endmodule

// [test_processor_register_set.sv]
// Self-checking bench for the processor register set
`timescale 1ns/1ps
module test_processor_register_set
	import prs_pkg::*;
;
	logic clk, sys_rst, reg_wr, reg_rd, instr_valid, privileged, fault_taken, ext_interrupt;
	logic mem_req, mem_fixed, mem_write, timer_fault_req, interrupt_accept, mem_valid;
	logic mem_range_err, got_par_ok;
	logic [4:0] reg_addr;
	logic [35:0] reg_wdata, reg_rdata, rv;
	prs_instr_type instr_word;
	prs_use_type instr_use;
	logic [17:0] eff_addr, indicator_set, low_mem_base;
	logic [5:0] shift_count, char_mask;
	logic [9:0] opcode_field;
	logic [1:0] mod_kind;
	logic [23:0] slot_map;
	logic [3:0] installed_blocks;
	prs_mem_type mem_out;
	logic [19:0] got_addr;
	logic [7:0] got_cnt;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	prs_register_set prs_register_set_i(.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .instr_valid, .instr_word, .instr_use, .eff_addr, .shift_count, .opcode_field,
		.mod_kind, .privileged, .fault_taken, .ext_interrupt, .timer_fault_req, .interrupt_accept,
		.indicator_set, .slot_map, .installed_blocks, .low_mem_base, .mem_req, .mem_fixed,
		.mem_write, .char_mask, .mem_out, .mem_valid, .mem_range_err);
	prs_mem_model prs_mem_model_i(.clk, .sys_rst, .mem_out, .mem_valid, .got_addr, .got_par_ok,
		.got_cnt);
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			final_report;
		end
	end
	task automatic final_report;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [75:0] seen, input logic [75:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [35:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		rv = reg_rdata;
	endtask
	task automatic ins(input logic [17:0] y, input logic [1:0] tm, input logic [3:0] td,
		input prs_use_type u);
		@(posedge clk);
		instr_valid <= 1'b1;
		instr_use <= u;
		instr_word <= '{y, 10'h2B7, 1'b0, 1'b0, tm, td};
		@(posedge clk);
		instr_valid <= 1'b0;
		@(negedge clk);
	endtask
	function automatic logic [35:0] wmask(input logic [4:0] a);
		if (a < 5'h02) return 36'hFFFFFFFFF;
		if (a == PRS_REG_EXP) return 36'h0000000FF;
		return 36'h00003FFFF;
	endfunction
	task automatic t_reset;
		for (int a = 0; a < 32; a++) begin
			rd(5'(a));
			chk("reset", rv, 36'h0);
		end
		$display("test reset done");
	endtask
	task automatic t_regs;
		logic [35:0] d;
		for (int a = 0; a < 15; a++) begin
			if (a != 13) begin
				d = 36'hFEDCBA987 ^ 36'(a);
				wr(5'(a), d);
				rd(5'(a));
				chk("reg", rv, d & wmask(5'(a)));
			end
		end
		wr(5'h15, 36'hFFFFFFFFF);
		rd(5'h15);
		chk("unmapped", rv, 36'h0);
		wr(PRS_REG_STAT, 36'hFFFFFFFFF);
		rd(PRS_REG_STAT);
		chk("status", rv, 36'h00000001E);
		wr(PRS_REG_IND, 36'h0);
		@(posedge clk);
		indicator_set <= 18'h00021;
		@(posedge clk);
		indicator_set <= 18'h00000;
		rd(PRS_REG_IND);
		chk("indicators", rv, 36'h000000021);
		$display("test regs done");
	endtask
	task automatic t_instr;
		logic [3:0] tdl[6] = '{PRS_TD_AU, PRS_TD_QU, PRS_TD_DU, PRS_TD_AL, PRS_TD_QL, PRS_TD_DL};
		logic [17:0] adl[6] = '{18'h00015, 18'h00045, 18'h00005, 18'h00025, 18'h00085, 18'h00005};
		wr(PRS_REG_ACC_UP, {18'h00010, 18'h00020});
		wr(PRS_REG_ACC_LO, {18'h00040, 18'h00080});
		for (int n = 0; n < 8; n++) wr(5'(2 + n), 36'(n * 18'h00111));
		for (int n = 0; n < 8; n++) begin
			ins(18'h00005, PRS_TM_REG, 4'(8 + n), PRS_USE_OPERAND);
			chk("index", eff_addr, 18'(5 + n * 18'h00111));
		end
		for (int n = 0; n < 6; n++) begin
			ins(18'h00005, PRS_TM_REG, tdl[n], PRS_USE_OPERAND);
			chk("half", {eff_addr, opcode_field, mod_kind}, {adl[n], 10'h2B7, 2'h0});
		end
		ins(18'h3FFF0, 2'h1, PRS_TD_AU, PRS_USE_OPERAND);
		chk("tm", {eff_addr, mod_kind}, {18'h3FFF0, 2'h1});
		ins(18'h3FFFF, PRS_TM_REG, 4'h9, PRS_USE_OPERAND);
		chk("wrap", eff_addr, 18'h00110);
		ins(18'h00047, 2'h1, PRS_TD_NONE, PRS_USE_SHIFT);
		chk("shift", shift_count, 6'h07);
		ins(18'h01234, 2'h1, PRS_TD_NONE, PRS_USE_TRANSFER);
		rd(PRS_REG_NIP);
		chk("transfer", rv, 36'h000001234);
		ins(18'h00005, 2'h1, PRS_TD_NONE, PRS_USE_OPERAND);
		rd(PRS_REG_NIP);
		chk("step", rv, 36'h000001235);
		ins(18'h00005, PRS_TM_REG, PRS_TD_NIP, PRS_USE_SUBOP);
		rd(PRS_REG_NIP);
		chk("ptr", {eff_addr, rv}, {18'h0123A, 36'h000001236});
		$display("test instr done");
	endtask
	task automatic t_mem;
		logic [17:0] yl[4] = '{18'h0ABCD, 18'h1F123, 18'h2ABCD, 18'h00010};
		logic fl[4] = '{1'b0, 1'b0, 1'b0, 1'b1};
		logic wl[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
		logic [71:0] dx = {18'h00010, 18'h00020, 18'h00040, 18'h00080};
		logic [17:0] ea;
		logic [2:0] s, blk;
		for (int i = 0; i < 4; i++) begin
			ins(yl[i], 2'h1, PRS_TD_NONE, PRS_USE_OPERAND);
			@(posedge clk);
			mem_req <= 1'b1;
			mem_fixed <= fl[i];
			mem_write <= wl[i];
			char_mask <= 6'h15;
			@(posedge clk);
			mem_req <= 1'b0;
			@(negedge clk);
			ea = yl[i] + (fl[i] ? 18'h00200 : 18'h00000);
			s = ea[17:15];
			blk = slot_map[3 * s +: 3];
			chk("range", {mem_valid, mem_range_err}, (s > 3'h3) ? 2'b01 : 2'b10);
			if (s < 3'h4) begin
				chk("phys", {mem_out.channel, mem_out.phys_addr}, {blk[2:1], blk, ea[14:0]});
				chk("mask", {mem_out.write, mem_out.char_mask}, {wl[i], wl[i] ? 6'h15 : 6'h3F});
				chk("data", {mem_out.data, mem_out.parity}, {dx, ^dx[71:36], ^dx[35:0]});
				@(negedge clk);
				chk("far", {got_par_ok, got_addr}, {1'b1, blk[2:1], blk, ea[14:0]});
			end
		end
		chk("count", got_cnt, 8'h03);
		$display("test mem done");
	endtask
	task automatic t_timer;
		int n = 0;
		wr(PRS_REG_TMR, 36'h000000002);
		while (timer_fault_req !== 1'b1 && n < 900) begin
			@(negedge clk);
			n++;
		end
		chk("gap", n > 390 && n < 810, 1'b1);
		chk("accept", interrupt_accept, 1'b1);
		@(posedge clk);
		instr_valid <= 1'b1;
		instr_word <= '{18'h0, 10'h2B7, 1'b1, 1'b0, 2'h1, 4'h0};
		@(negedge clk);
		chk("inhibit", {timer_fault_req, interrupt_accept}, 2'b00);
		@(posedge clk);
		instr_valid <= 1'b0;
		fault_taken <= 1'b1;
		@(posedge clk);
		fault_taken <= 1'b0;
		privileged <= 1'b1;
		@(negedge clk);
		chk("taken", timer_fault_req, 1'b0);
		wr(PRS_REG_TMR, 36'h000000001);
		n = 0;
		rv = 36'h0;
		while (rv[5] !== 1'b1 && n < 300) begin
			rd(PRS_REG_STAT);
			n++;
		end
		chk("held", {rv[5], timer_fault_req}, 2'b10);
		@(posedge clk);
		privileged <= 1'b0;
		@(negedge clk);
		chk("release", timer_fault_req, 1'b1);
		@(posedge clk);
		fault_taken <= 1'b1;
		ext_interrupt <= 1'b1;
		@(posedge clk);
		fault_taken <= 1'b0;
		@(negedge clk);
		chk("ext", {timer_fault_req, interrupt_accept}, 2'b01);
		@(posedge clk);
		ext_interrupt <= 1'b0;
		$display("test timer done");
	endtask
	initial begin
		sys_rst = 1'b1;
		{reg_wr, reg_rd, instr_valid, privileged, fault_taken, ext_interrupt} = 6'h00;
		{mem_req, mem_fixed, mem_write} = 3'h0;
		reg_addr = 5'h00;
		reg_wdata = 36'h0;
		instr_word = '0;
		instr_use = PRS_USE_OPERAND;
		indicator_set = 18'h00000;
		char_mask = 6'h00;
		slot_map = 24'h053977;
		installed_blocks = 4'h4;
		low_mem_base = 18'h00200;
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset;
		t_regs;
		t_instr;
		t_mem;
		t_timer;
		final_report;
	end
endmodule
